/* File: design/sbt_lin_if.sv */
`timescale 1ns/1ps
interface sbt_lin_if import sbt_pkg::*;;
    logic line;
    logic [13:0] bit_cyc;
    logic [13:0] sample_cyc;
    logic [3:0] brk_len;
    logic [5:0] id_cfg;
    sbt_lin_cond_type cond;
    logic trig;

    modport ctrl (output line, output bit_cyc, output sample_cyc, output brk_len,
                  output id_cfg, output cond, input trig);
    modport rx (input line, input bit_cyc, input sample_cyc, input brk_len,
                input id_cfg, input cond, output trig);
endinterface

/* File: design/sbt_lin_rx.sv */
`timescale 1ns/1ps
`include "sbt_params.svh"
module sbt_lin_rx import sbt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    sbt_lin_if.rx lif
);
    logic [17:0] low_cnt;
    logic [13:0] bit_cnt;
    logic [3:0] bit_idx;
    logic [9:0] frame;
    logic second;
    sbt_lin_state_type state;
    sbt_lin_state_type next_state;
    logic trig;

    wire [17:0] brk_thr = lif.brk_len * lif.bit_cyc;
    wire brk_hit = !lif.line && (low_cnt == brk_thr - 18'h00001);
    wire in_bits = (state == SBT_L_BITS);
    wire sample_now = in_bits && (bit_cnt == lif.sample_cyc);
    wire bit_end = in_bits && (bit_cnt == lif.bit_cyc - 14'h0001);
    wire byte_end = bit_end && (bit_idx == `SBT_LIN_LAST_BIT);
    wire id_hit = byte_end && second && frame[9] && (frame[6:1] == lif.id_cfg);
    wire next_trig = (lif.cond == SBT_FRAME_BREAK_DETECT) ? brk_hit : id_hit;

    always_comb
    begin
        next_state = state;
        if (brk_hit)
            next_state = SBT_L_DELIM;
        else
        begin
            unique case (state)
                SBT_L_HUNT: next_state = SBT_L_HUNT;
                SBT_L_DELIM: if (lif.line) next_state = SBT_L_WAIT;
                SBT_L_WAIT: if (!lif.line) next_state = SBT_L_BITS;
                SBT_L_BITS: if (byte_end) next_state = second ? SBT_L_HUNT : SBT_L_WAIT;
                default: next_state = SBT_L_HUNT;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_cnt <= 18'h00000;
            state <= SBT_L_HUNT;
            trig <= 1'b0;
        end
        else
        begin
            low_cnt <= lif.line ? 18'h00000 : ((&low_cnt) ? low_cnt : low_cnt + 18'h00001);
            state <= next_state;
            trig <= next_trig;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_cnt <= 14'h0000;
            bit_idx <= 4'h0;
            frame <= 10'h000;
            second <= 1'b0;
        end
        else
        begin
            bit_cnt <= (!in_bits || bit_end) ? 14'h0000 : bit_cnt + 14'h0001;
            bit_idx <= !in_bits ? 4'h0 : (bit_end ? bit_idx + 4'h1 : bit_idx);
            if (sample_now)
                frame <= {lif.line, frame[9:1]};
            if (state == SBT_L_DELIM)
                second <= 1'b0;
            else if (byte_end)
                second <= 1'b1;
        end
    end

    assign lif.trig = trig;

    property p_lin_pulse;
        @(posedge mclk) disable iff (!rst_n) lif.trig |=> !lif.trig;
    endproperty
    a_lin_pulse: assert property (p_lin_pulse) else $error("LIN trigger longer than a cycle");

    property p_break;
        @(posedge mclk) disable iff (!rst_n)
            (lif.cond == SBT_FRAME_BREAK_DETECT && brk_hit) |=> lif.trig;
    endproperty
    a_break: assert property (p_break) else $error("Break trigger missed");

    property p_id;
        @(posedge mclk) disable iff (!rst_n)
            (lif.cond == SBT_FRAME_ID_MATCH && id_hit) |=> lif.trig ##1 !lif.trig;
    endproperty
    a_id: assert property (p_id) else $error("Identifier trigger missed");

endmodule // sbt_lin_rx

/* File: design/sbt_params.svh */
`ifndef SBT_PARAMS_SVH
`define SBT_PARAMS_SVH

`define SBT_CLK_HZ 20000000
`define SBT_BAUD_LO 2400
`define SBT_BAUD_MID 9600
`define SBT_BAUD_HI 19200
`define SBT_BAUD_LO_W 16'h0960
`define SBT_BAUD_MID_W 16'h2580

`define SBT_SRC_ANALOG_END 5'h04
`define SBT_SRC_EXT 5'h04
`define SBT_SRC_DIG0 5'h05
`define SBT_SRC_DIG_LAST 5'h14

`define SBT_DONT_CARE 32'hffffffff
`define SBT_ADDR7_MAX 32'h0000007f
`define SBT_ADDR10_MAX 32'h000003ff
`define SBT_DATA_MAX 32'h000000ff
`define SBT_TEN_BIT_HDR 5'h1e
`define SBT_EEPROM_CODE 4'ha
`define SBT_BYTE_LAST 3'h7

`define SBT_SP_600 10'h258
`define SBT_SP_625 10'h271
`define SBT_SP_680 10'h2a8
`define SBT_SP_700 10'h2bc
`define SBT_SP_750 10'h2ee
`define SBT_SP_800 10'h320
`define SBT_SP_875 10'h36b
`define SBT_PERMILLE_DIV 24'h0003e8

`define SBT_BRK_MIN 4'hb
`define SBT_BRK_MAX 4'hd
`define SBT_LIN_LAST_BIT 4'h9

`endif

/* File: design/sbt_pkg.sv */
package sbt_pkg;

    typedef enum logic [3:0] {
        SBT_ON_START = 4'h0,
        SBT_ON_STOP = 4'h1,
        SBT_READ_SEVEN_BIT_FRAME = 4'h2,
        SBT_EEPROM_FETCH_MATCH = 4'h3,
        SBT_WRITE_SEVEN_BIT_FRAME = 4'h4,
        SBT_WRITE_TEN_BIT_FRAME = 4'h5,
        SBT_MISSING_ACK = 4'h6,
        SBT_ADDRESS_NOT_ACKED = 4'h7,
        SBT_READ_TWO_BYTE_FRAME = 4'h8,
        SBT_WRITE_TWO_BYTE_FRAME = 4'h9,
        SBT_ON_RESTART = 4'ha
    } sbt_kind_type;

    typedef enum logic [1:0] {
        SBT_MATCH_EQUAL = 2'h0,
        SBT_MATCH_DIFFER = 2'h1,
        SBT_MATCH_BELOW = 2'h2,
        SBT_MATCH_ABOVE = 2'h3
    } sbt_relation_type;

    typedef enum logic {
        SBT_FRAME_BREAK_DETECT = 1'b0,
        SBT_FRAME_ID_MATCH = 1'b1
    } sbt_lin_cond_type;

    typedef enum logic [7:0] {
        SBT_I_IDLE = 8'h01,
        SBT_I_ADDR = 8'h02,
        SBT_I_AACK = 8'h04,
        SBT_I_ADDR2 = 8'h08,
        SBT_I_A2ACK = 8'h10,
        SBT_I_DATA1 = 8'h20,
        SBT_I_D1ACK = 8'h40,
        SBT_I_DATA2 = 8'h80
    } sbt_i2c_state_type;

    typedef enum logic [3:0] {
        SBT_L_HUNT = 4'h1,
        SBT_L_DELIM = 4'h2,
        SBT_L_WAIT = 4'h4,
        SBT_L_BITS = 4'h8
    } sbt_lin_state_type;

endpackage

/* File: design/sbt_top.sv */
// Behaviour
// - Each monitored line comes from four analog, external or sixteen digital inputs.
// - EEPROM reads compare data by equal, differ, below or above relation.
// - Trigger on start, on stop, or on a start repeated before stop.
// - Seven-bit read frame: address and read, ack, matching data byte.
// - Two-byte read frame adds ack and a second byte matching second pattern.
// - Seven-bit write frame: address and write, ack, matching data byte.
// - Two-byte write frame adds ack and a second byte matching second pattern.
// - Ten-bit write frame: two address bytes, write, ack, then data byte.
// - Trigger on any missing ack, or only on an unacknowledged address.
// - Recognise a serial EEPROM data read and apply the data relation.
// - LIN identifier mode triggers when a frame identifier equals the setting.
// - LIN bits are sampled at a chosen fraction of bit time.
// - Every sample position is accepted at every baud rate.
// - LIN bit time follows 2400, 9600 or 19200 bits per second.
// - A nonstandard rate request selects the next higher standard rate, or 19200 when above 19200.
// - Address pattern holds 7 or 10 bits; all ones ignores the address.
// - Each data pattern holds 8 bits; all ones ignores that byte.
// - Sync break mode triggers on a low of 11, 12 or 13 bits.
// - LIN condition selects break detection or identifier matching.
`timescale 1ns/1ps
`include "sbt_params.svh"
module sbt_top import sbt_pkg::*;
#(
    parameter logic [13:0] BIT_CYC_2400 = 14'(`SBT_CLK_HZ / `SBT_BAUD_LO)
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [3:0] analog_in,
    input wire logic ext_in,
    input wire logic [15:0] digital_in,
    input wire logic [4:0] scl_source,
    input wire logic [4:0] sda_source,
    input wire logic [4:0] lin_source,
    input wire sbt_kind_type i2c_kind,
    input wire sbt_relation_type data_relation,
    input wire logic [31:0] address_pattern,
    input wire logic [31:0] data_pattern,
    input wire logic [31:0] data2_pattern,
    input wire sbt_lin_cond_type lin_condition,
    input wire logic [5:0] lin_id,
    input wire logic [15:0] baud_request,
    input wire logic [2:0] bit_sample_position,
    input wire logic [3:0] break_length,
    output logic i2c_trigger,
    output logic lin_trigger_out
);
    localparam logic [13:0] BIT_CYC_9600 = 14'(`SBT_CLK_HZ / `SBT_BAUD_MID);
    localparam logic [13:0] BIT_CYC_19200 = 14'(`SBT_CLK_HZ / `SBT_BAUD_HI);

    function automatic logic pick_source(input logic [4:0] sel, input logic [3:0] an,
                                         input logic ext, input logic [15:0] dig);
        logic [4:0] didx;
        didx = sel - `SBT_SRC_DIG0;
        if (sel < `SBT_SRC_ANALOG_END)
            return an[sel[1:0]];
        else if (sel == `SBT_SRC_EXT)
            return ext;
        else if (sel <= `SBT_SRC_DIG_LAST)
            return dig[didx[3:0]];
        return 1'b0;
    endfunction

    function automatic logic data_ok(input logic [31:0] pat, input logic [7:0] byte_in);
        return (pat == `SBT_DONT_CARE) || (pat <= `SBT_DATA_MAX && pat[7:0] == byte_in);
    endfunction

    function automatic logic addr_fits(input logic [31:0] pat, input logic [31:0] lim,
                                       input logic [9:0] field, input logic [9:0] value);
        return (pat == `SBT_DONT_CARE) || (pat <= lim && (pat[9:0] & field) == value);
    endfunction

    wire scl_mux = pick_source(scl_source, analog_in, ext_in, digital_in);
    wire sda_mux = pick_source(sda_source, analog_in, ext_in, digital_in);
    wire lin_mux = pick_source(lin_source, analog_in, ext_in, digital_in);

    logic scl_meta, scl_s, scl_q;
    logic sda_meta, sda_s, sda_q;
    logic lin_meta, lin_s;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {scl_meta, scl_s, scl_q} <= 3'h7;
            {sda_meta, sda_s, sda_q} <= 3'h7;
            {lin_meta, lin_s} <= 2'h3;
        end
        else
        begin
            {scl_meta, scl_s, scl_q} <= {scl_mux, scl_meta, scl_s};
            {sda_meta, sda_s, sda_q} <= {sda_mux, sda_meta, sda_s};
            {lin_meta, lin_s} <= {lin_mux, lin_meta};
        end
    end

    wire start_evt = scl_s && scl_q && sda_q && !sda_s;
    wire stop_evt = scl_s && scl_q && !sda_q && sda_s;
    wire bit_evt = scl_s && !scl_q;

    sbt_i2c_state_type state;
    sbt_i2c_state_type next_state;
    logic [6:0] shift;
    logic [2:0] bit_cnt;
    logic in_frame;
    logic frame_trig;

    wire [7:0] full_byte = {shift, sda_s};
    wire byte_state = (state == SBT_I_ADDR) || (state == SBT_I_ADDR2) ||
                      (state == SBT_I_DATA1) || (state == SBT_I_DATA2);
    wire byte_done = bit_evt && byte_state && (bit_cnt == `SBT_BYTE_LAST);
    wire nacked = sda_s;

    wire kind_read = (i2c_kind == SBT_READ_SEVEN_BIT_FRAME) ||
                     (i2c_kind == SBT_READ_TWO_BYTE_FRAME);
    wire kind_write = (i2c_kind == SBT_WRITE_SEVEN_BIT_FRAME) ||
                      (i2c_kind == SBT_WRITE_TWO_BYTE_FRAME);
    wire kind_two = (i2c_kind == SBT_READ_TWO_BYTE_FRAME) ||
                    (i2c_kind == SBT_WRITE_TWO_BYTE_FRAME);
    wire kind_ten = (i2c_kind == SBT_WRITE_TEN_BIT_FRAME);
    wire kind_nack = (i2c_kind == SBT_MISSING_ACK) || (i2c_kind == SBT_ADDRESS_NOT_ACKED);
    wire kind_eeprom = (i2c_kind == SBT_EEPROM_FETCH_MATCH);

    wire addr7_ok = addr_fits(address_pattern, `SBT_ADDR7_MAX, 10'h07f,
                              {3'h0, full_byte[7:1]});
    wire addr10_hi_ok = addr_fits(address_pattern, `SBT_ADDR10_MAX, 10'h300,
                                  {full_byte[2:1], 8'h00});
    wire addr10_lo_ok = addr_fits(address_pattern, `SBT_ADDR10_MAX, 10'h0ff,
                                  {2'h0, full_byte});
    wire ten_hdr = (full_byte[7:3] == `SBT_TEN_BIT_HDR) && !full_byte[0];
    wire eeprom_hdr = (full_byte[7:4] == `SBT_EEPROM_CODE) && full_byte[0];

    wire data1_ok = data_ok(data_pattern, full_byte);
    wire data2_ok = data_ok(data2_pattern, full_byte);
    wire rel_below = full_byte < data_pattern[7:0];
    wire rel_above = full_byte > data_pattern[7:0];
    wire rel_equal = full_byte == data_pattern[7:0];
    wire rel_ok = (data_pattern == `SBT_DONT_CARE) ||
                  (data_relation == SBT_MATCH_EQUAL && rel_equal) ||
                  (data_relation == SBT_MATCH_DIFFER && !rel_equal) ||
                  (data_relation == SBT_MATCH_BELOW && rel_below) ||
                  (data_relation == SBT_MATCH_ABOVE && rel_above);

    wire addr_accept = (kind_read && addr7_ok && full_byte[0]) ||
                       (kind_write && addr7_ok && !full_byte[0]) ||
                       (kind_ten && ten_hdr && addr10_hi_ok) ||
                       (kind_eeprom && eeprom_hdr) || kind_nack;

    always_comb
    begin
        next_state = state;
        frame_trig = 1'b0;
        if (start_evt)
            next_state = SBT_I_ADDR;
        else if (stop_evt)
            next_state = SBT_I_IDLE;
        else if (bit_evt)
        begin
            unique case (state)
                SBT_I_IDLE: next_state = SBT_I_IDLE;
                SBT_I_ADDR: if (byte_done) next_state = addr_accept ? SBT_I_AACK : SBT_I_IDLE;
                SBT_I_AACK:
                begin
                    frame_trig = nacked && kind_nack;
                    if (nacked)
                        next_state = SBT_I_IDLE;
                    else
                        next_state = kind_ten ? SBT_I_ADDR2 : SBT_I_DATA1;
                end
                SBT_I_ADDR2: if (byte_done) next_state = addr10_lo_ok ? SBT_I_A2ACK : SBT_I_IDLE;
                SBT_I_A2ACK: next_state = nacked ? SBT_I_IDLE : SBT_I_DATA1;
                SBT_I_DATA1:
                begin
                    if (byte_done)
                    begin
                        frame_trig = ((kind_read || kind_write) && !kind_two && data1_ok) ||
                                     (kind_ten && data1_ok) ||
                                     (kind_eeprom && rel_ok);
                        next_state = ((kind_two && data1_ok) || i2c_kind == SBT_MISSING_ACK) ?
                                     SBT_I_D1ACK : SBT_I_IDLE;
                    end
                end
                SBT_I_D1ACK:
                begin
                    frame_trig = nacked && (i2c_kind == SBT_MISSING_ACK);
                    if (nacked)
                        next_state = SBT_I_IDLE;
                    else
                        next_state = kind_two ? SBT_I_DATA2 : SBT_I_DATA1;
                end
                SBT_I_DATA2:
                begin
                    if (byte_done)
                    begin
                        frame_trig = data2_ok;
                        next_state = SBT_I_IDLE;
                    end
                end
                default: next_state = SBT_I_IDLE;
            endcase
        end
    end

    wire next_i2c_trigger = (i2c_kind == SBT_ON_START && start_evt) ||
                            (i2c_kind == SBT_ON_STOP && stop_evt) ||
                            (i2c_kind == SBT_ON_RESTART && start_evt && in_frame) ||
                            frame_trig;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= SBT_I_IDLE;
            shift <= 7'h00;
            bit_cnt <= 3'h0;
            in_frame <= 1'b0;
            i2c_trigger <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (bit_evt)
                shift <= full_byte[6:0];
            bit_cnt <= (next_state != state || start_evt) ? 3'h0 :
                       (bit_evt ? bit_cnt + 3'h1 : bit_cnt);
            in_frame <= start_evt ? 1'b1 : (stop_evt ? 1'b0 : in_frame);
            i2c_trigger <= next_i2c_trigger;
        end
    end

    wire [13:0] bit_cyc = (baud_request <= `SBT_BAUD_LO_W) ? BIT_CYC_2400 :
                          (baud_request <= `SBT_BAUD_MID_W) ? BIT_CYC_9600 :
                          BIT_CYC_19200;
    wire [9:0] permille = (bit_sample_position == 3'h0) ? `SBT_SP_600 :
                          (bit_sample_position == 3'h1) ? `SBT_SP_625 :
                          (bit_sample_position == 3'h2) ? `SBT_SP_680 :
                          (bit_sample_position == 3'h3) ? `SBT_SP_700 :
                          (bit_sample_position == 3'h4) ? `SBT_SP_750 :
                          (bit_sample_position == 3'h5) ? `SBT_SP_800 :
                          `SBT_SP_875;
    wire [23:0] sample_prod = bit_cyc * permille;
    wire [23:0] sample_quot = sample_prod / `SBT_PERMILLE_DIV;
    wire [3:0] brk_len = (break_length < `SBT_BRK_MIN) ? `SBT_BRK_MIN :
                         (break_length > `SBT_BRK_MAX) ? `SBT_BRK_MAX : break_length;

    sbt_lin_if lif ();
    assign lif.line = lin_s;
    assign lif.bit_cyc = bit_cyc;
    assign lif.sample_cyc = sample_quot[13:0];
    assign lif.brk_len = brk_len;
    assign lif.id_cfg = lin_id;
    assign lif.cond = lin_condition;

    sbt_lin_rx u_lin_rx (
        .mclk(mclk),
        .rst_n(rst_n),
        .lif(lif.rx)
    );

    assign lin_trigger_out = lif.trig;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_sync;
        sda_s == $past(sda_mux, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("Data line not two stages delayed");

    property p_pulse;
        i2c_trigger |=> !i2c_trigger;
    endproperty
    a_pulse: assert property (p_pulse) else $error("Trigger longer than a cycle");

    property p_start;
        (i2c_kind == SBT_ON_START && start_evt) |=> i2c_trigger;
    endproperty
    a_start: assert property (p_start) else $error("Start trigger missed");

    property p_stop;
        (i2c_kind == SBT_ON_STOP && stop_evt) |=> i2c_trigger;
    endproperty
    a_stop: assert property (p_stop) else $error("Stop trigger missed");

    property p_restart;
        (i2c_kind == SBT_ON_RESTART && start_evt && !in_frame) |=> !i2c_trigger;
    endproperty
    a_restart: assert property (p_restart) else $error("First start taken as restart");

    property p_abandon;
        (stop_evt && !start_evt) |=> state == SBT_I_IDLE;
    endproperty
    a_abandon: assert property (p_abandon) else $error("Frame kept after stop");

    property p_addr_nack;
        (i2c_kind == SBT_ADDRESS_NOT_ACKED && state == SBT_I_AACK && bit_evt && !start_evt &&
         !stop_evt && sda_s) |=> i2c_trigger ##1 state == SBT_I_IDLE;
    endproperty
    a_addr_nack: assert property (p_addr_nack) else $error("Address nack missed");

    property p_rate;
        (baud_request > `SBT_BAUD_LO_W && baud_request <= `SBT_BAUD_MID_W)
            |-> bit_cyc == BIT_CYC_9600;
    endproperty
    a_rate: assert property (p_rate) else $error("Rate not rounded up");

    property p_sample;
        lif.sample_cyc < bit_cyc && lif.sample_cyc > (bit_cyc >> 1);
    endproperty
    a_sample: assert property (p_sample) else $error("Sample point outside bit");

    c_start: cover property (i2c_kind == SBT_ON_START && i2c_trigger);
    c_read: cover property (i2c_kind == SBT_READ_SEVEN_BIT_FRAME && i2c_trigger);
    c_nack: cover property (i2c_kind == SBT_MISSING_ACK && i2c_trigger);
    c_lin: cover property (lin_trigger_out);

endmodule // sbt_top

/* File: verification/sbt_bus_model.sv */
`timescale 1ns/1ps
module sbt_bus_model
#(
    parameter int BIT = 40
)
(
    input wire logic mclk,
    output logic scl,
    output logic sda,
    output logic lin
);
    // All three lines are pulled up, so released lines read high.
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
        lin = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic start();
        scl = 1'b0;
        w(2);
        sda = 1'b1;
        w(2);
        scl = 1'b1;
        w(4);
        sda = 1'b0;
        w(4);
    endtask
    // Eight bits MSB first and then the ack bit, one per 400 ns clock.
    task automatic bits(input logic [8:0] v);
        for (int i = 8; i >= 0; i--)
        begin
            scl = 1'b0;
            w(2);
            sda = v[i];
            w(2);
            scl = 1'b1;
            w(4);
        end
    endtask
    task automatic stop();
        scl = 1'b0;
        w(2);
        sda = 1'b0;
        w(2);
        scl = 1'b1;
        w(4);
        sda = 1'b1;
        w(8);
    endtask
    task automatic lin_low(input int n);
        lin = 1'b0;
        w(n);
        lin = 1'b1;
        w(2 * BIT);
    endtask
    task automatic lin_byte(input logic [7:0] b);
        for (int i = 0; i < 10; i++)
        begin
            lin = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
            w(BIT);
        end
    endtask
endmodule // sbt_bus_model

/* File: verification/serial_bus_trigger_bench.sv */
`timescale 1ns/1ps
module serial_bus_trigger_bench import sbt_pkg::*;;
    localparam int BC = 40;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] seed = 32'h0000dd93;
    logic [16:0] noise = 17'h0;
    logic scl;
    logic sda;
    logic lin;
    wire logic [3:0] analog_in = {noise[2:0], lin};
    wire logic [15:0] digital_in = {noise[16:3], scl, sda};
    logic [4:0] scl_sel = 5'h04;
    logic [4:0] sda_sel = 5'h05;
    logic [4:0] lin_sel = 5'h00;
    sbt_kind_type kind = SBT_ON_START;
    sbt_relation_type rel = SBT_MATCH_EQUAL;
    sbt_lin_cond_type lcond = SBT_FRAME_BREAK_DETECT;
    logic [31:0] ap = 32'hffffffff;
    logic [31:0] dp = 32'hffffffff;
    logic [31:0] d2p = 32'hffffffff;
    logic [5:0] lid = 6'h00;
    logic [15:0] baud = 16'h0960;
    logic [2:0] sp = 3'h0;
    logic [3:0] bl = 4'hb;
    logic i2c_trigger;
    logic lin_trigger_out;
    int fails = 0;
    int num_checks = 0;
    int trig_seen = 0;
    int lin_seen = 0;
    sbt_bus_model #(.BIT(BC)) u_bus (.mclk(mclk), .scl(scl), .sda(sda), .lin(lin));
    sbt_top #(.BIT_CYC_2400(14'd40)) u_dut (.mclk(mclk), .rst_n(rst_n),
        .analog_in(analog_in), .ext_in(scl), .digital_in(digital_in),
        .scl_source(scl_sel), .sda_source(sda_sel), .lin_source(lin_sel), .i2c_kind(kind),
        .data_relation(rel), .address_pattern(ap), .data_pattern(dp),
        .data2_pattern(d2p), .lin_condition(lcond), .lin_id(lid), .baud_request(baud),
        .bit_sample_position(sp), .break_length(bl), .i2c_trigger(i2c_trigger),
        .lin_trigger_out(lin_trigger_out));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Trigger count that the frame must raise; ak holds the three ack bits, 1 = nack.
    function automatic int exp_i2c(input int k, input bit rs, input logic [7:0] ab,
                                   input logic [7:0] d1, input logic [7:0] d2,
                                   input logic [2:0] ak);
        bit ok;
        bit m1;
        bit m2;
        bit rl;
        ok = !ak[2] && (ap == 32'hffffffff || ap == {25'h0, ab[7:1]});
        m1 = dp == 32'hffffffff || dp == {24'h0, d1};
        m2 = d2p == 32'hffffffff || d2p == {24'h0, d2};
        rl = dp == 32'hffffffff || (rel == SBT_MATCH_EQUAL ? d1 == dp[7:0] :
             rel == SBT_MATCH_DIFFER ? d1 != dp[7:0] :
             rel == SBT_MATCH_BELOW ? d1 < dp[7:0] : d1 > dp[7:0]);
        case (k)
            0: return rs ? 2 : 1;
            1: return 1;
            2: return ok && ab[0] && m1;
            3: return !ak[2] && ab[0] && ab[7:4] == 4'ha && rl;
            4: return ok && !ab[0] && m1;
            5: return ab[7:3] == 5'h1e && !ab[0] && ak[2:1] == 2'b00
                   && (ap == 32'hffffffff || ap == {22'h0, ab[2:1], d1})
                   && (dp == 32'hffffffff || dp == {24'h0, d2});
            6: return |ak;
            7: return ak[2];
            8: return ok && ab[0] && m1 && !ak[1] && m2;
            9: return ok && !ab[0] && m1 && !ak[1] && m2;
            default: return rs;
        endcase
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        forever #25 mclk = ~mclk;
    end
    always @(negedge mclk)
    begin
        noise <= 17'(rnd());
        if (i2c_trigger === 1'b1)
            trig_seen++;
        if (lin_trigger_out === 1'b1)
            lin_seen++;
    end
    initial
    begin
        #4000000;
        fails++;
        summarize();
    end
    initial
    begin
        logic [31:0] x;
        logic [31:0] y;
        logic [7:0] ab;
        int t0;
        repeat (12) @(negedge mclk);
        check({i2c_trigger, lin_trigger_out}, 32'h0);
        rst_n = 1'b1;
        u_bus.w(10);
        for (int i = 0; i < 44; i++)
        begin
            x = rnd();
            y = rnd();
            ab = x[7:0];
            if (x[9:8] == 2'h1)
                ab[7:4] = 4'ha;
            if (x[9:8] == 2'h2)
                ab[7:3] = 5'h1e;
            kind = sbt_kind_type'(i % 11);
            scl_sel = i[0] ? 5'h06 : 5'h04;
            rel = sbt_relation_type'(y[7:6]);
            ap = y[0] ? 32'hffffffff : (i % 11 == 5 ? {22'h0, ab[2:1], x[17:10]} : ab[7:1]);
            ap ^= {31'h0, y[1] & !y[0]};
            dp = y[2] ? 32'hffffffff : {24'h0, (i % 11 == 5 ? x[25:18] : x[17:10]) ^ y[3]};
            d2p = y[4] ? 32'hffffffff : {24'h0, x[25:18] ^ {7'h0, y[5]}};
            t0 = trig_seen;
            if (y[8])
                u_bus.start();
            u_bus.start();
            u_bus.bits({ab, x[26] & x[29]});
            u_bus.bits({x[17:10], x[27] & x[30]});
            u_bus.bits({x[25:18], x[28] & x[31]});
            u_bus.stop();
            u_bus.w(10);
            check(trig_seen - t0, exp_i2c(i % 11, y[8], ab, x[17:10], x[25:18],
                  {x[26] & x[29], x[27] & x[30], x[28] & x[31]}));
        end
        for (int j = 0; j < 7; j++)
        begin
            bl = 4'(11 + j % 3);
            baud = (j == 6) ? 16'd15000 : (j == 3) ? 16'd5000 : 16'(rnd() % 2401);
            sp = 3'(j);
            t0 = lin_seen;
            u_bus.lin_low(j == 6 ? 11 * 1041 + 10 :
                          j == 3 ? 11 * 2083 - 8 : bl * BC + (j < 3 ? 8 : -8));
            check(lin_seen - t0, j < 3 || j == 6);
        end
        lcond = SBT_FRAME_ID_MATCH;
        baud = 16'd2400;
        for (int j = 0; j < 7; j++)
        begin
            x = rnd();
            lid = x[5:0];
            sp = 3'(j);
            t0 = lin_seen;
            u_bus.lin_low(13 * BC + 20);
            u_bus.lin_byte(8'h55);
            u_bus.lin_byte({x[7:6], x[5:0] ^ {5'h0, j[0]}});
            u_bus.w(10);
            check(lin_seen - t0, !j[0]);
        end
        summarize();
    end
endmodule // serial_bus_trigger_bench
